// [logic/asbw_host_ctrl.sv]
// Overview of operation
// - Write only while lane and strobe low
// - Write cycle meets least cycle time
// - Address valid long before write ends
// - Strobe overlap meets least pulse width
// - Data valid long before write ends
// - Strobe stays high during every read
`timescale 1ns/1ps
`default_nettype none
module asbw_host_ctrl
    import asbw_pkg::*;
#(
    parameter bit FAST_GRADE = 1'b0
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // User request port
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic [LANES-1:0] lane_en_i,
    output var logic ready_o,
    output var logic done_o,
    output var logic [DATA_W-1:0] rdata_o,
    // Memory pins
    output var logic [ADDR_W-1:0] word_index_lines_o,
    output var logic [LANES-1:0] byte_lane_select_n_o,
    output var logic write_strobe_n_o,
    output var logic out_drive_en_n_o,
    input wire logic [DATA_W-1:0] bidir_data_lines_i,
    output var logic [DATA_W-1:0] bidir_data_lines_o,
    output var logic bidir_data_lines_oe_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Grade-selected cycle counts

    // Overlap must cover pulse, address-to-end and data-to-end figures
    localparam int WP_CYC = FAST_GRADE ? WP_FAST_CYC : WP_SLOW_CYC;
    localparam int AW_CYC = FAST_GRADE ? AW_FAST_CYC : AW_SLOW_CYC;
    localparam int WC_CYC = FAST_GRADE ? WC_FAST_CYC : WC_SLOW_CYC;
    localparam int ACC_CYC = FAST_GRADE ? ACC_FAST_CYC : ACC_SLOW_CYC;
    localparam int PUL_A = (WP_CYC > AW_CYC) ? WP_CYC : AW_CYC;
    localparam int PUL_CYC = (PUL_A > DW_CYC) ? PUL_A : DW_CYC;
    localparam logic [CNT_W-1:0] PUL_LOAD = CNT_W'(PUL_CYC - 1);
    localparam logic [CNT_W-1:0] ACC_LOAD = CNT_W'(ACC_CYC);

    ////////////////////////////////////////////////////////////////////////////
    // State and latched request

    asbw_state_e state_r; // Sequencer state
    asbw_state_e state_nxt;
    logic [CNT_W-1:0] cnt_r; // Pulse and access countdown
    logic [CNT_W-1:0] cnt_nxt;
    logic [LANES-1:0] lane_r; // Lanes of current access

    // Decode of request and countdown end
    wire logic take_req = (state_r == ST_IDLE) && req_i;
    wire logic cnt_zero = (cnt_r == '0);
    wire logic sample_rd = (state_r == ST_RACC) && cnt_zero;

    // Next state; address and lanes never move inside a cycle
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        unique case (state_r)
            ST_IDLE: begin
                if (req_i) begin
                    state_nxt = we_i ? ST_WSET : ST_RACC;
                    cnt_nxt = we_i ? PUL_LOAD : ACC_LOAD;
                end
            end
            // Lanes go low first, strobe still high
            ST_WSET: state_nxt = ST_WPUL;
            ST_WPUL: begin
                if (cnt_zero) begin
                    state_nxt = ST_WEND;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            // Strobe up, lanes still low, data held
            ST_WEND: state_nxt = ST_WREC;
            // Recovery cycle keeps the address up past the least cycle time
            ST_WREC: state_nxt = ST_IDLE;
            ST_RACC: begin
                if (cnt_zero) begin
                    state_nxt = ST_RDONE;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            ST_RDONE: state_nxt = ST_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin next values, decoded from next state

    wire logic sel_nxt = (state_nxt != ST_IDLE) && (state_nxt != ST_WREC)
        && (state_nxt != ST_RDONE);
    wire logic [LANES-1:0] lanes_req = take_req ? lane_en_i : lane_r;
    wire logic [LANES-1:0] lanes_n_nxt = sel_nxt ? ~lanes_req : LANES_IDLE;
    wire logic strobe_n_nxt = (state_nxt != ST_WPUL);
    // Device outputs only when reading; off for the whole write
    wire logic g_n_nxt = (state_nxt != ST_RACC);
    // Host drives data from setup to end, G already high
    wire logic oe_nxt = (state_nxt == ST_WSET) || (state_nxt == ST_WPUL)
        || (state_nxt == ST_WEND);

    // Sequencer registers
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
            lane_r <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            lane_r <= lanes_req;
        end
    end

    // Pin and user registers; address and data latched only when idle
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            word_index_lines_o <= '0;
            bidir_data_lines_o <= '0;
            byte_lane_select_n_o <= LANES_IDLE;
            write_strobe_n_o <= STROBE_IDLE;
            out_drive_en_n_o <= STROBE_IDLE;
            bidir_data_lines_oe_o <= 1'b0;
            ready_o <= 1'b0;
            done_o <= 1'b0;
            rdata_o <= '0;
        end else begin
            if (take_req) begin
                word_index_lines_o <= addr_i;
                bidir_data_lines_o <= wdata_i;
            end
            byte_lane_select_n_o <= lanes_n_nxt;
            write_strobe_n_o <= strobe_n_nxt;
            out_drive_en_n_o <= g_n_nxt;
            bidir_data_lines_oe_o <= oe_nxt;
            ready_o <= (state_nxt == ST_IDLE) && !take_req;
            done_o <= (state_nxt == ST_WREC) || (state_nxt == ST_RDONE);
            if (sample_rd) begin
                rdata_o <= bidir_data_lines_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the pins this controller drives

    // Helper counts: strobe low length and address hold length
    logic [CNT_W-1:0] wlow_cnt_r;
    logic [CNT_W-1:0] avld_cnt_r;
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wlow_cnt_r <= '0;
            avld_cnt_r <= '0;
        end else begin
            wlow_cnt_r <= write_strobe_n_o ? '0 : wlow_cnt_r + 1'b1;
            avld_cnt_r <= take_req ? '0 : ((avld_cnt_r == '1) ? avld_cnt_r
                : avld_cnt_r + 1'b1);
        end
    end

    AST_WRITE_NEEDS_LANE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        !write_strobe_n_o |-> (byte_lane_select_n_o != LANES_IDLE))
        else $error("Strobe low with no lane selected");
    AST_LANES_MATCH_REQ: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        $fell(write_strobe_n_o) |-> (byte_lane_select_n_o == ~lane_r))
        else $error("Selected lanes differ from request");
    AST_G_OFF_IN_WRITE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        !write_strobe_n_o |-> out_drive_en_n_o && $past(out_drive_en_n_o))
        else $error("Output drive enable active near write");
    AST_LANE_BEFORE_STROBE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        $fell(write_strobe_n_o) |-> $stable(byte_lane_select_n_o))
        else $error("Lanes moved as strobe fell");
    AST_LANE_AFTER_STROBE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        $rose(write_strobe_n_o) |-> $stable(byte_lane_select_n_o) ##1
        (byte_lane_select_n_o == LANES_IDLE))
        else $error("Lanes did not rise after strobe");
    AST_CYCLE_TIME: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        take_req && (state_r == ST_IDLE) && $past(state_r == ST_WREC) |->
        ($past(avld_cnt_r) >= CNT_W'(WC_CYC)))
        else $error("Write cycle shorter than least cycle time");
    AST_OVERLAP_WIDTH: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        $rose(write_strobe_n_o) |-> (wlow_cnt_r >= CNT_W'(PUL_CYC))
        && (avld_cnt_r >= CNT_W'(AW_CYC)))
        else $error("Strobe overlap too short");
    AST_DATA_BEFORE_END: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        $rose(write_strobe_n_o) |-> bidir_data_lines_oe_o && $past(bidir_data_lines_oe_o)
        && $stable(bidir_data_lines_o))
        else $error("Write data not held to end of write");
    AST_NO_CONTENTION: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        bidir_data_lines_oe_o |-> out_drive_en_n_o)
        else $error("Host drives data while device enabled");
    AST_QUIET_AFTER_WRITE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        $rose(write_strobe_n_o) |-> out_drive_en_n_o [*2])
        else $error("Device enabled right after strobe rose");
    AST_READ_STROBE_HIGH: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        !out_drive_en_n_o |-> write_strobe_n_o)
        else $error("Strobe low during read");
    AST_ADDR_STABLE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        !write_strobe_n_o |-> $stable(word_index_lines_o) && $stable(byte_lane_select_n_o))
        else $error("Address or lanes moved in overlap");

endmodule // asbw_host_ctrl
`default_nettype wire

// [logic/asbw_pkg.sv]
`default_nettype none
// Shared constants for the host side of the byte-lane SRAM write/read port
package asbw_pkg;
    // Pin widths and counter width
    localparam int ADDR_W = 19;
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    localparam int CNT_W = 4;
    // Reference clock period in picoseconds (40 MHz)
    localparam int CLK_PERIOD_PS = 25000;
    // Write cycle time, fast and slow grade, ns
    localparam int T_WC_FAST_NS = 20;
    localparam int T_WC_SLOW_NS = 25;
    // Address valid to end of write, ns
    localparam int T_AW_FAST_NS = 15;
    localparam int T_AW_SLOW_NS = 17;
    // Strobe and lane overlap width, ns
    localparam int T_WP_FAST_NS = 15;
    localparam int T_WP_SLOW_NS = 17;
    // Data valid to end of write, both grades, ns
    localparam int T_DW_NS = 10;
    // Device release after strobe falls, ns (longest)
    localparam int T_WZ_FAST_NS = 9;
    localparam int T_WZ_SLOW_NS = 10;
    // Device quiet after strobe rises, ns (least)
    localparam int T_WHQX_NS = 5;
    // Read access time, ns
    localparam int T_ACC_FAST_NS = 20;
    localparam int T_ACC_SLOW_NS = 25;

    // Least time in ns to whole cycles, rounded up, never below one
    function automatic int ns2cyc(input int ns);
        int c;
        c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    // Derived cycle counts
    localparam int WC_FAST_CYC = ns2cyc(T_WC_FAST_NS);
    localparam int WC_SLOW_CYC = ns2cyc(T_WC_SLOW_NS);
    localparam int AW_FAST_CYC = ns2cyc(T_AW_FAST_NS);
    localparam int AW_SLOW_CYC = ns2cyc(T_AW_SLOW_NS);
    localparam int WP_FAST_CYC = ns2cyc(T_WP_FAST_NS);
    localparam int WP_SLOW_CYC = ns2cyc(T_WP_SLOW_NS);
    localparam int DW_CYC = ns2cyc(T_DW_NS);
    localparam int WZ_SLOW_CYC = ns2cyc(T_WZ_SLOW_NS);
    localparam int WHQX_CYC = ns2cyc(T_WHQX_NS);
    localparam int ACC_FAST_CYC = ns2cyc(T_ACC_FAST_NS);
    localparam int ACC_SLOW_CYC = ns2cyc(T_ACC_SLOW_NS);

    // Reset levels of the strobes (all idle high)
    localparam logic [LANES-1:0] LANES_IDLE = 4'hF;
    localparam logic STROBE_IDLE = 1'h1;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WSET,
        ST_WPUL,
        ST_WEND,
        ST_WREC,
        ST_RACC,
        ST_RDONE
    } asbw_state_e;
endpackage : asbw_pkg
`default_nettype wire

// [test/asbw_sram_model.sv]
`timescale 1ns/1ps
`default_nettype none
module asbw_sram_model
    import asbw_pkg::*;
(
    // Memory pins from the host
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [LANES-1:0] lane_n_i,
    input wire logic we_n_i,
    input wire logic oe_n_i,
    // Host drive and resolved bus
    input wire logic [DATA_W-1:0] host_dq_i,
    input wire logic host_oe_i,
    output var logic [DATA_W-1:0] bus_o,
    output var logic clash_o
);
    logic [DATA_W-1:0] mem [int]; // Sparse word store
    logic [LANES-1:0] act_r = '0; // Lanes inside an open write
    logic we_q = 1'h1; // Strobe after the quiet time
    logic [DATA_W-1:0] last_r = '0; // Last value of host_dq_i, driven or not
    logic [DATA_W-1:0] word; // Word under update or read
    logic drv; // Device drives the bus
    //////////////////////////////////////////////////////////////////////
    // Each lane stores when its overlap with the strobe ends
    always @(lane_n_i or we_n_i) begin
        word = mem.exists(int'(addr_i)) ? mem[int'(addr_i)] : '0;
        for (int k = 0; k < LANES; k++) begin
            if (act_r[k] && (lane_n_i[k] || we_n_i)) begin
                word[8*k +: 8] = bus_o[8*k +: 8];
            end
        end
        mem[int'(addr_i)] = word;
        act_r = ~lane_n_i & {LANES{~we_n_i}};
    end
    // Both edges reach we_q after the quiet time; we_n_i gates falls at once
    always @(we_n_i) we_q <= #(T_WHQX_NS) we_n_i;
    // Output enable is ignored while the strobe is low
    assign drv = we_n_i && we_q && !oe_n_i;
    always @(posedge host_oe_i or negedge host_oe_i or host_dq_i) last_r = host_dq_i;
    //////////////////////////////////////////////////////////////////////
    // Undriven bytes show the inverse of the last value, never a stale copy
    always @(addr_i or lane_n_i or drv or host_oe_i or host_dq_i or last_r) begin
        for (int k = 0; k < LANES; k++) begin
            bus_o[8*k +: 8] = ~last_r[8*k +: 8];
            if (drv && !lane_n_i[k] && mem.exists(int'(addr_i))) begin
                bus_o[8*k +: 8] = mem[int'(addr_i)][8*k +: 8];
            end
        end
        if (host_oe_i) begin
            bus_o = host_dq_i;
        end
        clash_o = host_oe_i && drv;
    end
endmodule // asbw_sram_model
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import asbw_pkg::*;
    logic ref_clk_i = 1'h0;
    logic resetn_i = 1'h0;
    logic req_i = 1'h0;
    logic we_i = 1'h0;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [DATA_W-1:0] wdata_i = '0;
    logic [LANES-1:0] lane_en_i = '0;
    logic ready_o, done_o, wsn, oen, doe, clash, pwsn;
    logic [DATA_W-1:0] rdata_o, dq_o, bus, d0, d1, q;
    logic [ADDR_W-1:0] wil, pwil, a;
    logic [LANES-1:0] bls, pbls;
    int mismatches = 0;
    int tests_run = 0;
    int seed;
    asbw_host_ctrl u_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .req_i(req_i),
        .we_i(we_i), .addr_i(addr_i), .wdata_i(wdata_i), .lane_en_i(lane_en_i),
        .ready_o(ready_o), .done_o(done_o), .rdata_o(rdata_o), .word_index_lines_o(wil),
        .byte_lane_select_n_o(bls), .write_strobe_n_o(wsn), .out_drive_en_n_o(oen),
        .bidir_data_lines_i(bus), .bidir_data_lines_o(dq_o), .bidir_data_lines_oe_o(doe));
    asbw_sram_model u_mem (.addr_i(wil), .lane_n_i(bls), .we_n_i(wsn), .oe_n_i(oen),
        .host_dq_i(dq_o), .host_oe_i(doe), .bus_o(bus), .clash_o(clash));
    initial begin
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    //////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input string what, input logic [DATA_W-1:0] exp,
                         input logic [DATA_W-1:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Bytes of the new word replace the old where the lane is set
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o,
        input logic [DATA_W-1:0] n, input logic [LANES-1:0] ln);
        for (int k = 0; k < LANES; k++) begin
            if (ln[k]) o[8*k +: 8] = n[8*k +: 8];
        end
        return o;
    endfunction
    // One request; bounded waits for ready and done
    task automatic access(input logic w, input logic [ADDR_W-1:0] ad,
        input logic [DATA_W-1:0] d, input logic [LANES-1:0] ln);
        int n;
        n = 0;
        while (ready_o !== 1'h1) begin
            @(posedge ref_clk_i);
            #1;
            n++;
            if (n > 20) begin
                mismatches++;
                end_sim();
            end
        end
        req_i = 1'h1;
        we_i = w;
        addr_i = ad;
        wdata_i = d;
        lane_en_i = ln;
        @(posedge ref_clk_i);
        #1;
        req_i = 1'h0;
        check("ready after take", 32'h0, DATA_W'(ready_o));
        n = 0;
        while (done_o !== 1'h1 && n < 20) begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        // Done three edges after a write is taken, two after a read
        check("done latency", w ? 32'h3 : 32'h2, DATA_W'(n));
        if (n >= 20) end_sim();
        q = rdata_o;
    endtask
    //////////////////////////////////////////////////////////////////////
    // Pin watch: strobe overlap, lane order, enable and bus ownership
    always @(posedge ref_clk_i) begin
        if (resetn_i) begin
            if (!wsn) check("enable during write", 32'h1, DATA_W'(oen));
            if (!wsn) check("lane low in write", 32'h1, DATA_W'(bls != 4'hF));
            if (!oen) check("strobe during read", 32'h1, DATA_W'(wsn));
            if (!wsn || !pwsn) check("lanes near strobe", DATA_W'(pbls), DATA_W'(bls));
            if (!wsn || !pwsn) check("address in write", DATA_W'(pwil), DATA_W'(wil));
            if (!wsn) check("data driven in write", 32'h1, DATA_W'(doe));
            check("bus clash", 32'h0, DATA_W'(clash));
        end
        pwsn <= wsn;
        pbls <= bls;
        pwil <= wil;
    end
    //////////////////////////////////////////////////////////////////////
    // Every nonzero lane mask over a full word, ends of the address range included
    initial begin
        seed = $urandom(90380);
        repeat (3) @(posedge ref_clk_i);
        #1;
        resetn_i = 1'h1;
        for (int k = 1; k < 16; k++) begin
            a = (k == 1) ? '0 : (k == 15) ? '1 : ADDR_W'($urandom);
            d0 = $urandom;
            d1 = $urandom;
            access(1'h1, a, d0, 4'hF);
            access(1'h1, a, d1, LANES'(k));
            access(1'h0, a, '0, 4'hF);
            check("read word", merge(d0, d1, LANES'(k)), q);
        end
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
